// [rtl/codec_port_defs.svh]
// Constants for the codec serial port: widths, depths, reset values
`ifndef CODEC_PORT_DEFS_SVH
`define CODEC_PORT_DEFS_SVH
`define CSP_WORD_BITS  16
`define CSP_FIFO_DEPTH 8
`define CSP_DIV_W      6
`define CSP_MIN_RATIO  6'h02
`define CSP_DIV_RESET  6'h00
`define CSP_BITS_RESET 4'h0
`define CSP_LAST_BIT   4'hf
`define CSP_WORD_RESET 16'h0000
`define CSP_SENT_BITS  5'h10
`endif

// [rtl/codec_port_pkg.sv]
// Types shared by the codec serial port
package codec_port_pkg;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_SYNC  = 3'b010,
    TX_SHIFT = 3'b100
  } txState_t;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b01,
    RX_SHIFT = 2'b10
  } rxState_t;
endpackage

// [rtl/codec_serial_port.sv]
// Codec serial port: bit clock divider, framed transmit and receive, FIFO
`timescale 1ns/1ps
`include "codec_port_defs.svh"

// Outgoing word buffer; contents survive a port disable
module csp_word_fifo #(
  parameter int WIDTH = `CSP_WORD_BITS,
  parameter int DEPTH = `CSP_FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [CW-1:0]    count_ff;
  logic [AW-1:0]    nxt_wrPtr;
  logic [AW-1:0]    nxt_rdPtr;
  logic [CW-1:0]    nxt_count;
  logic             doWr;
  logic             doRd;

  assign inReady  = (count_ff != CW'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData  = mem[rdPtr_ff];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  // Pointer and fill level update
  always_comb begin
    nxt_wrPtr = wrPtr_ff;
    nxt_rdPtr = rdPtr_ff;
    nxt_count = count_ff;
    if (doWr) begin
      nxt_wrPtr = (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
    end
    if (doRd) begin
      nxt_rdPtr = (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
    end
    if (doWr && !doRd) begin
      nxt_count = count_ff + 1'b1;
    end else if (doRd && !doWr) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end

  // Storage needs no reset; only words below count are ever read
  always_ff @(posedge sys_clk) begin
    if (doWr) begin
      mem[wrPtr_ff] <= inData;
    end
  end
endmodule

module codec_serial_port
  import codec_port_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        portEnablePin,
  input  wire logic [2:0]  mclkDivSel,
  input  wire logic [1:0]  sclkDivSel,
  input  wire logic [15:0] txData,
  input  wire logic        txValid,
  output logic             txReady,
  output logic      [15:0] rxData,
  output logic             rxValid,
  input  wire logic        refSelCh1,
  input  wire logic        refSelCh2,
  output logic             sclkOut,
  output logic             serialOutPin,
  output logic             serialOutOe,
  output logic             outFrameSync,
  output logic             outFrameSyncOe,
  input  wire logic        inFrameSync,
  input  wire logic        serialInPin,
  output logic             refHighSelect
);
  // Bit 2 enable, bit 1 input frame sync, bit 0 serial input
  logic [2:0] pinS1_ff, pinS2_ff, pinS3_ff, pinF_ff, nxt_pinF;
  logic       portEn, ifsF, sdiF;

  // Accept a new level only once two late stages agree
  function automatic logic [2:0] agreeFilt(input logic [2:0] held,
                                           input logic [2:0] a,
                                           input logic [2:0] b);
    agreeFilt = (~(a ^ b) & b) | ((a ^ b) & held);
  endfunction

  always_comb begin
    nxt_pinF = agreeFilt(pinF_ff, pinS2_ff, pinS3_ff);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinS1_ff <= 3'h0;
      pinS2_ff <= 3'h0;
      pinS3_ff <= 3'h0;
      pinF_ff  <= 3'h0;
    end else begin
      pinS1_ff <= {portEnablePin, inFrameSync, serialInPin};
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      pinF_ff  <= nxt_pinF;
    end
  end

  assign portEn = pinF_ff[2];
  assign ifsF   = pinF_ff[1] && portEn;
  assign sdiF   = pinF_ff[0] && portEn;

  // Bit clock divider; ratio of one is raised to two so both edges exist
  logic [3:0]            mSet;
  logic [2:0]            sSet;
  logic [`CSP_DIV_W-1:0] ratioRaw, ratio, half;
  logic [`CSP_DIV_W-1:0] divCnt_ff, nxt_divCnt;
  logic                  sclk_ff, nxt_sclk, riseEn, fallEn;

  assign mSet     = {1'b0, mclkDivSel} + 4'h1;
  assign sSet     = {1'b0, sclkDivSel} + 3'h1;
  assign ratioRaw = {2'b00, mSet} * {3'b000, sSet};
  assign ratio    = (ratioRaw < `CSP_MIN_RATIO) ? `CSP_MIN_RATIO : ratioRaw;
  assign half     = {1'b0, ratio[`CSP_DIV_W-1:1]};
  assign riseEn   = portEn && (divCnt_ff >= ratio - 1'b1);
  assign fallEn   = portEn && (divCnt_ff == half - 1'b1);

  always_comb begin
    nxt_divCnt = riseEn ? `CSP_DIV_RESET : divCnt_ff + 1'b1;
    nxt_sclk   = riseEn ? 1'b1 : (fallEn ? 1'b0 : sclk_ff);
    if (!portEn) begin
      nxt_divCnt = `CSP_DIV_RESET;
      nxt_sclk   = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_ff <= `CSP_DIV_RESET;
      sclk_ff   <= 1'b0;
    end else begin
      divCnt_ff <= nxt_divCnt;
      sclk_ff   <= nxt_sclk;
    end
  end

  assign sclkOut = sclk_ff;

  // Transmit side
  logic        fifoValid, fifoPop;
  logic [15:0] fifoData;

  csp_word_fifo #(
    .WIDTH (`CSP_WORD_BITS),
    .DEPTH (`CSP_FIFO_DEPTH)
  ) txFifo (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .inValid  (txValid),
    .inReady  (txReady),
    .inData   (txData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  txState_t    txState_ff, nxt_txState;
  logic [3:0]  txBits_ff, nxt_txBits;
  logic [15:0] txShift_ff, nxt_txShift;
  logic        sdo_ff, nxt_sdo, sdoOe_ff, nxt_sdoOe, ofs_ff, nxt_ofs;

  // While enabled, all pin changes happen on the rising-edge enable only
  always_comb begin
    nxt_txState = txState_ff;
    nxt_txBits  = txBits_ff;
    nxt_txShift = txShift_ff;
    nxt_sdo     = sdo_ff;
    nxt_sdoOe   = sdoOe_ff;
    nxt_ofs     = ofs_ff;
    fifoPop     = 1'b0;
    if (!portEn) begin
      nxt_txState = TX_IDLE;
      nxt_txBits  = `CSP_BITS_RESET;
      nxt_sdoOe   = 1'b0;
      nxt_ofs     = 1'b0;
    end else if (riseEn) begin
      case (txState_ff)
        TX_IDLE: begin
          if (fifoValid) begin
            fifoPop     = 1'b1;
            nxt_txShift = fifoData;
            nxt_ofs     = 1'b1;
            nxt_txState = TX_SYNC;
          end
        end
        TX_SYNC: begin
          nxt_ofs     = 1'b0;
          nxt_sdo     = txShift_ff[15];
          nxt_sdoOe   = 1'b1;
          nxt_txShift = {txShift_ff[14:0], 1'b0};
          nxt_txBits  = `CSP_LAST_BIT;
          nxt_txState = TX_SHIFT;
        end
        TX_SHIFT: begin
          if (txBits_ff == `CSP_BITS_RESET) begin
            nxt_sdoOe = 1'b0;
            if (fifoValid) begin
              fifoPop     = 1'b1;
              nxt_txShift = fifoData;
              nxt_ofs     = 1'b1;
              nxt_txState = TX_SYNC;
            end else begin
              nxt_txState = TX_IDLE;
            end
          end else begin
            nxt_sdo     = txShift_ff[15];
            nxt_txShift = {txShift_ff[14:0], 1'b0};
            nxt_txBits  = txBits_ff - 1'b1;
          end
        end
        default: begin
          nxt_txState = TX_IDLE;
          nxt_sdoOe   = 1'b0;
          nxt_ofs     = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txState_ff <= TX_IDLE;
      txBits_ff  <= `CSP_BITS_RESET;
      txShift_ff <= `CSP_WORD_RESET;
      sdo_ff     <= 1'b0;
      sdoOe_ff   <= 1'b0;
      ofs_ff     <= 1'b0;
    end else begin
      txState_ff <= nxt_txState;
      txBits_ff  <= nxt_txBits;
      txShift_ff <= nxt_txShift;
      sdo_ff     <= nxt_sdo;
      sdoOe_ff   <= nxt_sdoOe;
      ofs_ff     <= nxt_ofs;
    end
  end

  assign serialOutPin   = sdo_ff;
  assign serialOutOe    = sdoOe_ff;
  assign outFrameSync   = ofs_ff;
  assign outFrameSyncOe = portEn;

  // Receive side; a frame sync on the last bit starts the next word
  rxState_t    rxState_ff, nxt_rxState;
  logic [3:0]  rxBits_ff, nxt_rxBits;
  logic [15:0] rxShift_ff, nxt_rxShift, rxData_ff, nxt_rxData;
  logic        rxValid_ff, nxt_rxValid;

  always_comb begin
    nxt_rxState = rxState_ff;
    nxt_rxBits  = rxBits_ff;
    nxt_rxShift = rxShift_ff;
    nxt_rxData  = rxData_ff;
    nxt_rxValid = 1'b0;
    if (!portEn) begin
      nxt_rxState = RX_IDLE;
      nxt_rxBits  = `CSP_BITS_RESET;
    end else if (fallEn) begin
      case (rxState_ff)
        RX_IDLE: begin
          if (ifsF) begin
            nxt_rxState = RX_SHIFT;
            nxt_rxBits  = `CSP_BITS_RESET;
          end
        end
        RX_SHIFT: begin
          nxt_rxShift = {rxShift_ff[14:0], sdiF};
          nxt_rxBits  = rxBits_ff + 1'b1;
          if (rxBits_ff == `CSP_LAST_BIT) begin
            nxt_rxData  = {rxShift_ff[14:0], sdiF};
            nxt_rxValid = 1'b1;
            nxt_rxBits  = `CSP_BITS_RESET;
            nxt_rxState = ifsF ? RX_SHIFT : RX_IDLE;
          end
        end
        default: nxt_rxState = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxState_ff <= RX_IDLE;
      rxBits_ff  <= `CSP_BITS_RESET;
      rxShift_ff <= `CSP_WORD_RESET;
      rxData_ff  <= `CSP_WORD_RESET;
      rxValid_ff <= 1'b0;
    end else begin
      rxState_ff <= nxt_rxState;
      rxBits_ff  <= nxt_rxBits;
      rxShift_ff <= nxt_rxShift;
      rxData_ff  <= nxt_rxData;
      rxValid_ff <= nxt_rxValid;
    end
  end

  assign rxData  = rxData_ff;
  assign rxValid = rxValid_ff;

  // Reference level select is shared, so either channel can raise it
  logic refHigh_ff;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      refHigh_ff <= 1'b0;
    end else begin
      refHigh_ff <= refSelCh1 | refSelCh2;
    end
  end
  assign refHighSelect = refHigh_ff;

  // Checking helpers: bit clock period and bits sent per word
  logic [`CSP_DIV_W-1:0] gap_ff;
  logic                  gapOk_ff;
  logic [4:0]            sent_ff;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_ff   <= `CSP_DIV_RESET;
      gapOk_ff <= 1'b0;
      sent_ff  <= 5'h00;
    end else begin
      gap_ff   <= (riseEn || !portEn) ? `CSP_DIV_RESET : gap_ff + 1'b1;
      gapOk_ff <= portEn && $stable(ratio) && (gapOk_ff || riseEn);
      if (riseEn && txState_ff == TX_SYNC) begin
        sent_ff <= 5'h01;
      end else if (riseEn && txState_ff == TX_SHIFT &&
                   txBits_ff != `CSP_BITS_RESET) begin
        sent_ff <= sent_ff + 5'h01;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence syncSlot;
    riseEn && txState_ff == TX_SYNC;
  endsequence
  sequence wordEnd;
    riseEn && txState_ff == TX_SHIFT && txBits_ff == `CSP_BITS_RESET;
  endsequence

  frame_one_bit_a: assert property (
    syncSlot |-> outFrameSync ##1 (!outFrameSync && serialOutOe))
    else $error("frame sync not one bit before MSB");
  word_length_a: assert property (
    wordEnd |-> sent_ff == `CSP_SENT_BITS)
    else $error("outgoing word not sixteen bits");
  sdo_tristate_a: assert property (
    (!portEn or (wordEnd and !fifoValid)) |=> !serialOutOe)
    else $error("serial output driven when it must float");
  ofs_tristate_a: assert property (
    !portEn |-> !outFrameSyncOe ##1 !outFrameSync)
    else $error("frame sync driven while disabled");
  sdo_on_rise_a: assert property (
    (portEn && !riseEn) |=> $stable(serialOutPin) && $stable(outFrameSync))
    else $error("output changed off the rising edge");
  sclk_period_a: assert property (
    (riseEn && gapOk_ff) |-> gap_ff == ratio - 1'b1)
    else $error("bit clock period differs from divider product");
  sclk_gated_a: assert property (
    !portEn [*2] |-> !sclkOut && divCnt_ff == `CSP_DIV_RESET)
    else $error("bit clock runs while disabled");
  rx_ignore_a: assert property (
    !portEn |=> rxState_ff == RX_IDLE && !rxValid)
    else $error("input activity accepted while disabled");
  ifs_start_a: assert property (
    (fallEn && rxState_ff == RX_IDLE && ifsF) |=> rxState_ff == RX_SHIFT)
    else $error("input frame sync missed on falling edge");
  ref_or_a: assert property (
    (refSelCh1 || refSelCh2) |=> refHighSelect)
    else $error("reference select ignores a channel bit");
endmodule

// [tb/codec_serial_port_bench.sv]
// Self-checking bench for the codec serial port
`timescale 1ns/1ps
module codec_serial_port_bench;
  logic        sys_clk, rst_b, portEnablePin, txValid, txReady, rxValid;
  logic [2:0]  mclkDivSel;
  logic [1:0]  sclkDivSel;
  logic [15:0] txData, rxData, sendWord, gotWord;
  logic        refSelCh1, refSelCh2, sclkOut, serialOutPin, serialOutOe;
  logic        outFrameSync, outFrameSyncOe, inFrameSync, serialInPin;
  logic        refHighSelect, sendGo, sendBusy, gotStrobe, frameErr;
  integer      seed;
  int          nErrors, checkCount, i, n, e;
  logic [15:0] txExp[$];
  logic [15:0] rxExp[$];

  codec_serial_port dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .portEnablePin(portEnablePin), .mclkDivSel(mclkDivSel),
    .sclkDivSel(sclkDivSel), .txData(txData), .txValid(txValid),
    .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
    .refSelCh1(refSelCh1), .refSelCh2(refSelCh2), .sclkOut(sclkOut),
    .serialOutPin(serialOutPin), .serialOutOe(serialOutOe),
    .outFrameSync(outFrameSync), .outFrameSyncOe(outFrameSyncOe),
    .inFrameSync(inFrameSync), .serialInPin(serialInPin),
    .refHighSelect(refHighSelect));

  dsp_port_model dsp (.sys_clk(sys_clk), .rst_b(rst_b),
    .portEn(portEnablePin), .sclk(sclkOut), .serial_out_pin(serialOutPin),
    .sdoOe(serialOutOe), .outFs(outFrameSync), .sendGo(sendGo),
    .sendWord(sendWord), .sendBusy(sendBusy), .inFs(inFrameSync),
    .serial_in_pin(serialInPin), .gotWord(gotWord), .gotStrobe(gotStrobe),
    .frameErr(frameErr));

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // Outputs that must sit quiet in reset or while disabled
  task automatic quietCheck(input logic resetting);
    check("bit clock", 16'(sclkOut), 16'h0000);
    check("data oe", 16'(serialOutOe), 16'h0000);
    check("sync oe", 16'(outFrameSyncOe), 16'h0000);
    if (resetting) check("ready", 16'(txReady), 16'h0001);
  endtask

  // Offer one word and hold it until the FIFO takes it
  task automatic push(input logic [15:0] w);
    int k;
    txData  <= w;
    txValid <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (txReady !== 1'b1 && k < 5000);
    if (k >= 5000) nErrors++;
    txExp.push_back(w);
  endtask

  task automatic dspSend(input logic [15:0] w, input bit wait_done);
    int k;
    sendWord <= w;
    sendGo   <= 1'b1;
    cyc(1);
    sendGo <= 1'b0;
    cyc(1);
    k = 0;
    while (wait_done && sendBusy && k < 2000) begin
      cyc(1);
      k++;
    end
    if (k >= 2000) nErrors++;
  endtask

  task automatic waitRise(output int k);
    logic prev;
    k = 0;
    do begin
      prev = sclkOut;
      cyc(1);
      k++;
    end while (!(sclkOut && !prev) && k < 200);
  endtask

  // Reference model side: every word seen at either end is compared in order
  always @(posedge sys_clk) begin
    if (rst_b && gotStrobe)
      check("sent word", gotWord,
        txExp.size() > 0 ? txExp.pop_front() : 16'hxxxx);
    if (rst_b && rxValid)
      check("received word", rxData,
        rxExp.size() > 0 ? rxExp.pop_front() : 16'hxxxx);
    if (rst_b && frameErr)
      check("framing", 16'(frameErr), 16'h0000);
  end

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Generous span: the whole sequence needs roughly 7.5k cycles
  initial begin
    #400000;
    nErrors++;
    wrapUp();
  end

  initial begin
    seed = 32'hde8c9a69;
    {rst_b, txValid, refSelCh1, refSelCh2, sendGo} = 5'h00;
    portEnablePin = 1'b1;
    {mclkDivSel, sclkDivSel} = 5'h0f;
    {txData, sendWord} = 32'h0;
    nErrors = 0;
    checkCount = 0;
    cyc(11);
    quietCheck(1'b1);
    cyc(1);
    rst_b <= 1'b1;
    // Reference select is the OR of both channel bits
    for (i = 0; i < 4; i++) begin
      refSelCh1 <= i[0];
      refSelCh2 <= i[1];
      cyc(3);
      check("ref select", 16'(refHighSelect), 16'(i[0] | i[1]));
    end
    // Bit clock period is the product of both dividers, never below 2
    for (i = 0; i < 32; i++) begin
      mclkDivSel <= i[4:2];
      sclkDivSel <= i[1:0];
      e = (i[4:2] + 1) * (i[1:0] + 1);
      if (e < 2) e = 2;
      waitRise(n);
      waitRise(n);
      waitRise(n);
      check("bit clock period", 16'(n), 16'(e));
    end
    // Fill the FIFO while disabled; a ninth word is refused until it drains
    portEnablePin <= 1'b0;
    cyc(8);
    for (i = 0; i < 8; i++) push(16'($random(seed)));
    txData <= 16'($random(seed));
    for (i = 0; i < 20; i++) begin
      cyc(1);
      check("full", 16'(txReady), 16'h0000);
      quietCheck(1'b0);
    end
    portEnablePin <= 1'b1;
    push(txData);
    txValid <= 1'b0;
    cyc(10);
    check("sync oe", 16'(outFrameSyncOe), 16'h0001);
    // Traffic in both directions at once
    fork
      for (i = 0; i < 400 && txExp.size() > 0; i++) cyc(50);
      for (n = 0; n < 3; n++) begin
        rxExp.push_back(16'($random(seed)));
        dspSend(rxExp[rxExp.size()-1], 1'b1);
      end
    join
    check("left to send", 16'(txExp.size()), 16'h0000);
    // Disable in mid-frame: the partial word is dropped, the port restarts
    dspSend(16'h5a5a, 1'b0);
    cyc(120);
    portEnablePin <= 1'b0;
    cyc(30);
    portEnablePin <= 1'b1;
    cyc(20);
    rxExp.push_back(16'h8001);
    dspSend(16'h8001, 1'b1);
    cyc(20);
    check("left to receive", 16'(rxExp.size()), 16'h0000);
    // Reset in mid-run empties the FIFO
    portEnablePin <= 1'b0;
    push(16'h1234);
    txValid <= 1'b0;
    rst_b <= 1'b0;
    txExp.delete();
    cyc(3);
    quietCheck(1'b1);
    rst_b <= 1'b1;
    portEnablePin <= 1'b1;
    cyc(600);
    wrapUp();
  end
endmodule

// [tb/dsp_port_model.sv]
// Behavioural DSP on the far side of the codec serial port
`timescale 1ns/1ps
module dsp_port_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        portEn,
  input  wire logic        sclk,
  input  wire logic        serial_out_pin,
  input  wire logic        sdoOe,
  input  wire logic        outFs,
  input  wire logic        sendGo,
  input  wire logic [15:0] sendWord,
  output logic             sendBusy,
  output logic             inFs,
  output logic             serial_in_pin,
  output logic      [15:0] gotWord,
  output logic             gotStrobe,
  output logic             frameErr
);
  logic        sclkPrev;
  logic        sendReq;
  logic [15:0] word;
  logic [15:0] shiftIn;
  int          txCnt;
  int          rxCnt;

  assign sendBusy = sendReq || (txCnt != 0);

  // Bit clock edges are seen one system cycle late, so keep the ratio >= 16
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {sclkPrev, sendReq, inFs, serial_in_pin, gotStrobe, frameErr} <= 6'h00;
      {word, shiftIn, gotWord} <= 48'h0;
      txCnt <= 0;
      rxCnt <= 0;
    end else begin
      sclkPrev  <= sclk;
      gotStrobe <= 1'b0;
      frameErr  <= 1'b0;
      if (sendGo) begin
        sendReq <= 1'b1;
        word    <= sendWord;
      end
      if (txCnt == 0) inFs <= 1'b0;
      // Words out change on rise: one-bit sync, then MSB first
      if (sclk && !sclkPrev) begin
        if (txCnt > 1) begin
          inFs  <= 1'b0;
          serial_in_pin   <= word[txCnt-2];
          txCnt <= txCnt - 1;
        end else if (txCnt == 1) begin
          txCnt <= 0;
        end else if (sendReq) begin
          inFs    <= 1'b1;
          sendReq <= 1'b0;
          txCnt   <= 17;
        end
      end else if (txCnt == 0 || txCnt == 17) begin
        serial_in_pin <= ~serial_in_pin;  // Released line: never a stale bit
      end
      // Words from the device are taken on the bit clock fall
      if (!sclk && sclkPrev && rxCnt > 0) begin
        shiftIn <= {shiftIn[14:0], serial_out_pin};
        rxCnt   <= rxCnt - 1;
        if (!sdoOe || outFs) frameErr <= 1'b1;
        if (rxCnt == 1) begin
          gotWord   <= {shiftIn[14:0], serial_out_pin};
          gotStrobe <= 1'b1;
        end
      end else if (!sclk && sclkPrev) begin
        if (sdoOe) frameErr <= 1'b1;
        if (outFs) rxCnt <= 16;
      end
      // Port disabled: the device ignores these pins, so drive garbage
      if (!portEn) begin
        txCnt   <= 0;
        rxCnt   <= 0;
        sendReq <= 1'b0;
        inFs    <= ~inFs;
        serial_in_pin     <= ~serial_in_pin;
      end
    end
  end
endmodule
